// [rtl/oscar_pkg.sv]
// Operation
// - The emitter is driven during a proximity measurement at ten milliamperes per unit of the drive field.
// - A drive field above twenty is clamped to the two hundred milliampere maximum.
// - After reset the drive field holds two, giving twenty milliamperes.
// - The upper bits of the drive register read back a fixed trim revision code.
// - Bit seven of the ambient parameter register is a read/write continuous conversion control.
// - Bit three of the ambient parameter register enables automatic offset compensation.
// - Bits two to zero of the ambient parameter register pick the conversions per run, and the average is stored.
// - Each ambient result is one sixteen-bit unsigned value over two byte registers.
// - Result bits fifteen to eight read at address 85h and are read-only.
// - Result bits seven to zero read at address 86h and are read-only.
// - Writing one to the ambient single-shot bit of the command register starts one ambient measurement.
// - The ambient result-valid flag sets on new data and clears when either result register is read.
package oscar_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_COMMAND   = 8'h80;
	localparam logic [7:0] ADDR_DRIVE     = 8'h83;
	localparam logic [7:0] ADDR_AMB_PARAM = 8'h84;
	localparam logic [7:0] ADDR_RES_HIGH  = 8'h85;
	localparam logic [7:0] ADDR_RES_LOW   = 8'h86;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int         CMD_VALID_BIT  = 6;
	localparam int         CMD_SHOT_BIT   = 4;
	localparam int         PAR_CONT_BIT   = 7;
	localparam int         PAR_OFFS_BIT   = 3;
	localparam int         DRIVE_W        = 6;
	localparam logic [5:0] DRIVE_RESET    = 6'h02;
	localparam logic [5:0] DRIVE_MAX      = 6'h14;
	localparam logic [7:0] MA_PER_STEP    = 8'h0A;
	localparam logic [7:0] PARAM_RESET    = 8'h0D;
	localparam logic [1:0] TRIM_CODE      = 2'h1; // Arbitrary value
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_IDLE   = 2'b00,
		OSC_OFFSET = 2'b01,
		OSC_CONV   = 2'b10,
		OSC_STORE  = 2'b11
	} osc_state_e;
endpackage

// [rtl/oscar_accum.sv]
module oscar_accum
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	// Control
	input  wire logic        i_clear,
	input  wire logic        i_add,
	input  wire logic [15:0] i_sample,
	// Sum
	output logic      [23:0] o_sum
);
	// ------------------------------------------------------------
	// Sample accumulator
	// ------------------------------------------------------------
	logic [23:0] sum_r;
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			sum_r <= 24'h000000;
		else if (i_clear)
			sum_r <= 24'h000000;
		else if (i_add)
			sum_r <= sum_r + {8'h00, i_sample};
	end
	assign o_sum = sum_r;
endmodule

// [rtl/oscar_top.sv]
module oscar_top
(
	// Clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_sys_rst,
	// Register port (already decoded from the serial bus)
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Ambient converter
	output logic            o_conv_start,
	output logic            o_conv_dark,
	input  wire logic       i_conv_done,
	input  wire logic [15:0] i_conv_data,
	// Emitter drive
	input  wire logic       i_prox_active,
	output logic      [7:0] o_emitter_ma,
	// Status
	output logic            o_cont_mode,
	output logic            o_amb_valid,
	output logic            o_amb_busy
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [5:0]  drive_r;
	logic [7:0]  param_r;
	logic [15:0] result_r;
	logic        valid_r;
	logic [15:0] offset_r;
	logic [7:0]  left_r;
	logic        conv_pend_r;
	logic        shot_r;
	logic [7:0]  ma_r;
	logic [7:0]  rdata_r;
	oscar_pkg::osc_state_e state_r;
	oscar_pkg::osc_state_e state_nxt;
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire wr_cmd   = i_reg_wr && (i_reg_addr == oscar_pkg::ADDR_COMMAND);
	wire wr_drive = i_reg_wr && (i_reg_addr == oscar_pkg::ADDR_DRIVE);
	wire wr_param = i_reg_wr && (i_reg_addr == oscar_pkg::ADDR_AMB_PARAM);
	wire rd_res   = i_reg_rd && ((i_reg_addr == oscar_pkg::ADDR_RES_HIGH)
	                || (i_reg_addr == oscar_pkg::ADDR_RES_LOW));
	wire shot_req = wr_cmd && i_reg_wdata[oscar_pkg::CMD_SHOT_BIT];
	wire cont_on  = param_r[oscar_pkg::PAR_CONT_BIT];
	wire offs_on  = param_r[oscar_pkg::PAR_OFFS_BIT];
	wire idle     = (state_r == oscar_pkg::OSC_IDLE);
	wire go       = idle && (shot_r || cont_on);
	// Conversions per run: 1,2,4..128
	wire [8:0]  run_len = 9'h001 << param_r[2:0];
	wire [23:0] acc_sum;
	wire        acc_add = i_conv_done && conv_pend_r && (state_r == oscar_pkg::OSC_CONV);
	wire        last    = acc_add && (left_r == 8'h01);
	// Average by shift, then offset removal with floor at zero
	wire [23:0] avg     = acc_sum >> param_r[2:0];
	wire [15:0] avg16   = avg[15:0];
	wire [15:0] comp    = (offs_on && avg16 > offset_r) ? avg16 - offset_r
	                      : (offs_on ? 16'h0000 : avg16);
	// ------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------
	oscar_accum u_accum
	(
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_clear   (go),
		.i_add     (acc_add),
		.i_sample  (i_conv_data),
		.o_sum     (acc_sum)
	);
	// ------------------------------------------------------------
	// Sequencer next state
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			oscar_pkg::OSC_IDLE:
				if (go)
					state_nxt = offs_on ? oscar_pkg::OSC_OFFSET : oscar_pkg::OSC_CONV;
			oscar_pkg::OSC_OFFSET:
				if (i_conv_done && conv_pend_r)
					state_nxt = oscar_pkg::OSC_CONV;
			oscar_pkg::OSC_CONV:
				if (last)
					state_nxt = oscar_pkg::OSC_STORE;
			oscar_pkg::OSC_STORE:
				state_nxt = oscar_pkg::OSC_IDLE;
			default:
				state_nxt = oscar_pkg::OSC_IDLE;
		endcase
	end
	// ------------------------------------------------------------
	// Sequencer and converter handshake
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			state_r     <= oscar_pkg::OSC_IDLE;
			conv_pend_r <= 1'b0;
			left_r      <= 8'h00;
			offset_r    <= 16'h0000;
			o_conv_start <= 1'b0;
			o_conv_dark <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			o_conv_start <= 1'b0;
			// Run length is 1 to 128, so the low byte always holds it
			if (go)
				left_r <= run_len[7:0];
			else if (acc_add)
				left_r <= left_r - 8'h01;
			if (i_conv_done)
				conv_pend_r <= 1'b0;
			// Start a dark offset conversion or a light conversion
			if ((state_nxt == oscar_pkg::OSC_OFFSET || state_nxt == oscar_pkg::OSC_CONV)
			    && !conv_pend_r && !(i_conv_done && conv_pend_r) && !last)
			begin
				o_conv_start <= 1'b1;
				o_conv_dark  <= (state_nxt == oscar_pkg::OSC_OFFSET);
				conv_pend_r  <= 1'b1;
			end
			if (state_r == oscar_pkg::OSC_OFFSET && i_conv_done && conv_pend_r)
				offset_r <= i_conv_data;
		end
	end
	// ------------------------------------------------------------
	// Configuration and result registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			drive_r  <= oscar_pkg::DRIVE_RESET;
			param_r  <= oscar_pkg::PARAM_RESET;
			result_r <= 16'h0000;
			valid_r  <= 1'b0;
			shot_r   <= 1'b0;
		end
		else
		begin
			// Trim bits and result registers take no writes
			if (wr_drive)
				drive_r <= i_reg_wdata[5:0];
			if (wr_param)
				param_r <= {i_reg_wdata[7], 3'b000, i_reg_wdata[3:0]};
			if (shot_req)
				shot_r <= 1'b1;
			else if (go)
				shot_r <= 1'b0;
			if (state_r == oscar_pkg::OSC_STORE)
				result_r <= comp;
			// Set wins over a clearing read
			if (state_r == oscar_pkg::OSC_STORE)
				valid_r <= 1'b1;
			else if (rd_res)
				valid_r <= 1'b0;
		end
	end
	// ------------------------------------------------------------
	// Emitter current, clamped at the maximum
	// ------------------------------------------------------------
	wire [5:0] drive_eff = (drive_r > oscar_pkg::DRIVE_MAX) ? oscar_pkg::DRIVE_MAX : drive_r;
	wire [7:0] drive_ma  = 8'({2'b00, drive_eff} * oscar_pkg::MA_PER_STEP);
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ma_r <= 8'h00;
		else
			ma_r <= i_prox_active ? drive_ma : 8'h00;
	end
	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb
	begin
		case (i_reg_addr)
			oscar_pkg::ADDR_COMMAND:   rdata_r = {1'b1, valid_r, 1'b0, shot_r, 4'h0};
			oscar_pkg::ADDR_DRIVE:     rdata_r = {oscar_pkg::TRIM_CODE, drive_r};
			oscar_pkg::ADDR_AMB_PARAM: rdata_r = param_r;
			oscar_pkg::ADDR_RES_HIGH:  rdata_r = result_r[15:8];
			oscar_pkg::ADDR_RES_LOW:   rdata_r = result_r[7:0];
			default:                   rdata_r = 8'h00;
		endcase
	end
	assign o_reg_rdata  = rdata_r;
	assign o_emitter_ma = ma_r;
	assign o_cont_mode  = cont_on;
	assign o_amb_valid  = valid_r;
	assign o_amb_busy   = !idle;
	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_CLAMP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_prox_active |=> (o_emitter_ma <= 8'hC8)) else $error("emitter current over max");
	AST_SCALE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_prox_active && drive_r <= 6'h14) |=> (o_emitter_ma == 8'($past(drive_r) * 8'h0A)))
		else $error("emitter current scale wrong");
	AST_OFFCUR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_prox_active |=> (o_emitter_ma == 8'h00)) else $error("emitter on outside proximity");
	AST_VALID_SET: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state_r == oscar_pkg::OSC_STORE) |=> o_amb_valid) else $error("valid not set");
	AST_VALID_CLR: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(rd_res && state_r != oscar_pkg::OSC_STORE) |=> !o_amb_valid) else $error("valid not cleared");
	AST_RES_RO: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(state_r != oscar_pkg::OSC_STORE) |=> $stable(result_r)) else $error("result changed");
	AST_SHOT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(shot_req && idle) |-> ##[1:2] o_amb_busy) else $error("single shot not started");
	AST_HIGH: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_reg_addr == oscar_pkg::ADDR_RES_HIGH) |-> (o_reg_rdata == result_r[15:8]))
		else $error("high byte wrong");
	// Run start with and without offset compensation
	sequence seq_go_offs;
		go && offs_on;
	endsequence
	sequence seq_go_plain;
		go && !offs_on;
	endsequence
	// First converter request of a run
	sequence seq_dark_start;
		o_conv_start && o_conv_dark;
	endsequence
	sequence seq_light_start;
		o_conv_start && !o_conv_dark;
	endsequence
	AST_OFFSET_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		seq_go_offs |=> seq_dark_start) else $error("offset conversion not first");
	AST_NO_OFFSET: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		seq_go_plain |=> seq_light_start) else $error("offset conversion while disabled");
	AST_START_PULSE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_conv_start |=> !o_conv_start) else $error("converter start held");
endmodule

// [tb/oscar_conv_model.sv]
// Behavioural ambient converter: answers each start after a short delay
module oscar_conv_model
#(
	parameter logic [15:0] LIGHT = 16'h1234,
	parameter logic [15:0] DARK  = 16'h0034
)
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	// Control from bench and block
	input  wire logic        i_clear,
	input  wire logic        i_start,
	input  wire logic        i_dark,
	// Answer
	output logic             o_done,
	output logic      [15:0] o_data,
	output logic      [7:0]  o_starts
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]  wait_r;
	logic        busy_r;
	logic        dark_r;
	logic        odd_r;
	logic [15:0] last_r;

	// Light samples alternate by two so that averaging shows
	always_ff @(posedge i_clk_sys or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			{wait_r, busy_r, dark_r, odd_r, o_done} <= '0;
			last_r   <= 16'h0000;
			o_starts <= 8'h00;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_clear)
			begin
				o_starts <= 8'h00;
				odd_r    <= 1'b0;
			end
			if (i_start)
			begin
				busy_r   <= 1'b1;
				wait_r   <= 2'h2;
				dark_r   <= i_dark;
				o_starts <= o_starts + 8'h01;
			end
			else if (busy_r && wait_r == 2'h0)
			begin
				busy_r <= 1'b0;
				o_done <= 1'b1;
				last_r <= dark_r ? DARK : LIGHT + (odd_r ? 16'h0002 : 16'h0000);
				odd_r  <= dark_r ? odd_r : ~odd_r;
			end
			else if (busy_r)
				wait_r <= wait_r - 2'h1;
		end
	end

	// Data line shows garbage outside the done cycle
	assign o_data = o_done ? last_r : ~last_r;
endmodule

// [tb/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk_sys = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic        i_reg_wr = 1'b0;
	logic        i_reg_rd = 1'b0;
	logic [7:0]  i_reg_addr = 8'h00;
	logic [7:0]  i_reg_wdata = 8'h00;
	logic        i_prox_active = 1'b0;
	logic        mdl_clear = 1'b0;
	logic [7:0]  o_reg_rdata, o_emitter_ma, starts;
	logic        o_conv_start, o_conv_dark, conv_done, o_cont_mode, o_amb_valid, o_amb_busy;
	logic [15:0] conv_data;
	logic [7:0]  d;
	int          num_errors = 0;
	int          check_count = 0;

	// ------------------------------------------------------------
	// Block and converter
	// ------------------------------------------------------------
	oscar_top i_oscar_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_conv_start(o_conv_start), .o_conv_dark(o_conv_dark),
		.i_conv_done(conv_done), .i_conv_data(conv_data), .i_prox_active(i_prox_active),
		.o_emitter_ma(o_emitter_ma), .o_cont_mode(o_cont_mode), .o_amb_valid(o_amb_valid),
		.o_amb_busy(o_amb_busy));
	oscar_conv_model i_oscar_conv_model (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_clear(mdl_clear), .i_start(o_conv_start), .i_dark(o_conv_dark), .o_done(conv_done),
		.o_data(conv_data), .o_starts(starts));

	always #4 i_clk_sys = ~i_clk_sys;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One register access, write or read, held over one rising edge
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd);
		@(negedge i_clk_sys);
		{i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, ~w, a, wd};
		#1 d = o_reg_rdata;
		@(negedge i_clk_sys);
		{i_reg_wr, i_reg_rd} = 2'b00;
	endtask

	task automatic wait_valid();
		for (int k = 0; k < 500 && o_amb_valid !== 1'b1; k++)
			@(negedge i_clk_sys);
	endtask

	task automatic run(input logic [7:0] par, input logic [15:0] exp, input logic [7:0] n, input logic low);
		acc(1'b1, oscar_pkg::ADDR_AMB_PARAM, par);
		mdl_clear = 1'b1;
		@(negedge i_clk_sys);
		mdl_clear = 1'b0;
		acc(1'b1, oscar_pkg::ADDR_COMMAND, 8'h10);
		wait_valid();
		chk(starts, n);
		acc(1'b0, oscar_pkg::ADDR_COMMAND, 8'h00);
		chk(d[6], 1'b1);
		acc(1'b0, low ? oscar_pkg::ADDR_RES_LOW : oscar_pkg::ADDR_RES_HIGH, 8'h00);
		chk(o_amb_valid, 1'b0);
		acc(1'b0, oscar_pkg::ADDR_RES_HIGH, 8'h00);
		chk(d, exp[15:8]);
		acc(1'b0, oscar_pkg::ADDR_RES_LOW, 8'h00);
		chk(d, exp[7:0]);
	endtask

	task automatic test_reset();
		acc(1'b0, oscar_pkg::ADDR_DRIVE, 8'h00);
		chk(d, {oscar_pkg::TRIM_CODE, oscar_pkg::DRIVE_RESET});
		acc(1'b0, oscar_pkg::ADDR_AMB_PARAM, 8'h00);
		chk(d, oscar_pkg::PARAM_RESET);
		acc(1'b0, 8'h8B, 8'h00);
		chk(d, 8'h00);
	endtask

	task automatic test_drive();
		logic [7:0] v [4] = '{8'hFF, 8'h15, 8'h14, 8'hC7};
		logic [7:0] m [4] = '{8'hC8, 8'hC8, 8'hC8, 8'h46};
		i_prox_active = 1'b1;
		repeat (2) @(negedge i_clk_sys);
		chk(o_emitter_ma, 8'h14);
		for (int k = 0; k < 4; k++)
		begin
			acc(1'b1, oscar_pkg::ADDR_DRIVE, v[k]);
			@(negedge i_clk_sys);
			chk(o_emitter_ma, m[k]);
		end
		acc(1'b0, oscar_pkg::ADDR_DRIVE, 8'h00);
		chk(d, {oscar_pkg::TRIM_CODE, 6'h07});
		i_prox_active = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		chk(o_emitter_ma, 8'h00);
	endtask

	task automatic test_cont();
		acc(1'b1, oscar_pkg::ADDR_RES_HIGH, 8'hFF);
		acc(1'b1, oscar_pkg::ADDR_RES_LOW, 8'hFF);
		acc(1'b0, oscar_pkg::ADDR_RES_LOW, 8'h00);
		chk(d, 8'h00);
		acc(1'b0, oscar_pkg::ADDR_RES_HIGH, 8'h00);
		chk(d, 8'h12);
		acc(1'b1, oscar_pkg::ADDR_AMB_PARAM, 8'h80);
		chk(o_cont_mode, 1'b1);
		acc(1'b0, oscar_pkg::ADDR_AMB_PARAM, 8'h00);
		chk(d, 8'h80);
		wait_valid();
		chk(o_amb_valid, 1'b1);
		acc(1'b0, oscar_pkg::ADDR_RES_HIGH, 8'h00);
		chk(d, 8'h12);
		acc(1'b1, oscar_pkg::ADDR_AMB_PARAM, 8'h00);
		for (int k = 0; k < 500 && o_amb_busy !== 1'b0; k++)
			@(negedge i_clk_sys);
		chk(o_amb_busy, 1'b0);
	endtask

	// Reset after the last run has ended restores the defaults
	task automatic test_rereset();
		@(negedge i_clk_sys);
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_clk_sys);
		i_sys_rst = 1'b0;
		test_reset();
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (10) @(negedge i_clk_sys);
		i_sys_rst = 1'b0;
		test_reset();
		test_drive();
		run(8'h02, 16'h1235, 8'h04, 1'b0);
		run(8'h08, 16'h1200, 8'h02, 1'b1);
		test_cont();
		test_rereset();
		give_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge i_clk_sys);
		num_errors++;
		give_verdict();
	end
endmodule
